// >>> verilog/bid_pkg.sv
// Shared constants for the board identification and status lamp block.
package bid_pkg;

    // APB address width and data width.
    localparam int unsigned BID_ADDR_W    = 12;
    localparam int unsigned BID_DATA_W    = 32;

    // Number of identification switch positions.
    localparam int unsigned BID_ID_W      = 5;

    // Bit addresses on the bit-addressed I/O bus; each takes one APB word.
    localparam logic [BID_ADDR_W-1:0] BID_LAMP_OFS = 12'h000;
    localparam logic [BID_ADDR_W-1:0] BID_ID_OFS   = 12'h004;
    localparam logic [BID_ADDR_W-1:0] BID_WORD_STEP = 12'h004;

    // Position of the single data bit inside each APB word.
    localparam int unsigned BID_BIT_POS   = 0;

    // Lamp latch values: zero lights the lamp, one puts it out.
    localparam logic BID_LAMP_LIT = 1'b0;
    localparam logic BID_LAMP_OFF = 1'b1;

    // Switch register value after reset: every switch reads as open.
    localparam logic [BID_ID_W-1:0] BID_ID_RESET = 5'h1f;

endpackage : bid_pkg

// >>> verilog/bid_id_if.sv
`timescale 1ns/10ps
// Carries the registered switch levels from the sampler to the register logic.
interface bid_id_if #(
    parameter int unsigned ID_W = 5
);
    logic [ID_W-1:0] id_bits;  // Registered switch levels, one per position.

    // The sampler drives the levels.
    modport src (output id_bits);
    // The register logic reads them.
    modport dst (input id_bits);
endinterface : bid_id_if

// >>> verilog/bid_id_sampler.sv
`timescale 1ns/10ps
// Registers the identification switch levels once per clock.
module bid_id_sampler
    import bid_pkg::*;
#(
    parameter int unsigned ID_W = BID_ID_W
) (
    // Clock and reset.
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // Raw switch levels: open reads one, closed to ground reads zero.
    input  wire logic [ID_W-1:0] id_switch,
    // Registered levels toward the register logic.
    bid_id_if.src                id_out
);

    logic [ID_W-1:0] id_q;  // Sampled switch levels.
    logic [ID_W-1:0] id_d;  // Next sampled levels.

    // The switch level passes through unchanged, so open is one and closed is zero.
    always_comb begin
        id_d = id_switch;
    end

    // Reset shows all switches open so nothing reads as a closed switch before the first sample.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            id_q <= ID_W'(BID_ID_RESET);
        end else begin
            id_q <= id_d;
        end
    end

    assign id_out.id_bits = id_q;

endmodule : bid_id_sampler

// >>> verilog/bid_top.sv
`timescale 1ns/10ps
module bid_top
    import bid_pkg::*;
(
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // APB slave port.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [BID_ADDR_W-1:0] paddr,
    input  wire logic [BID_DATA_W-1:0] pwdata,
    output logic      [BID_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Identification switches and latch clear strobe.
    input  wire logic [BID_ID_W-1:0]   id_switch,
    input  wire logic                  io_latch_clear_strobe,
    // Lamp drive: low lights the lamp.
    output logic                       status_lamp_n
);

    // Registered switch levels from the sampler.
    bid_id_if #(.ID_W(BID_ID_W)) id_link ();

    // The sampler keeps the pin timing apart from the bus decode.
    bid_id_sampler #(
        .ID_W      (BID_ID_W)
    ) u_sampler (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .id_switch (id_switch),
        .id_out    (id_link.src)
    );

    logic [BID_ID_W-1:0]   id_now;      // Current switch levels seen by the bus.
    logic [BID_ID_W-1:0]   id_hit;      // One-hot match of the address on a switch word.
    logic                  lamp_hit;    // Address matches the lamp word.
    logic                  setup_ph;    // APB setup cycle.
    logic                  access_done; // Access cycle that completes this edge.

    logic [BID_DATA_W-1:0] prdata_q;    // Read data register.
    logic [BID_DATA_W-1:0] prdata_d;    // Next read data.
    logic                  pready_q;    // Ready register.
    logic                  pready_d;    // Next ready.
    logic                  pslverr_q;   // Error register.
    logic                  pslverr_d;   // Next error.
    logic                  lamp_q;      // Lamp latch, zero means lit.
    logic                  lamp_d;      // Next lamp latch.

    assign id_now      = id_link.id_bits;
    assign setup_ph    = psel && !penable;
    assign access_done = psel && penable && pready_q;
    assign lamp_hit    = (paddr == BID_LAMP_OFS);

    // Each switch position decodes its own word, one word after the previous.
    for (genvar k = 0; k < BID_ID_W; k++) begin : g_id_dec
        localparam logic [BID_ADDR_W-1:0] OFS = BID_ID_OFS + BID_WORD_STEP * BID_ADDR_W'(k);
        assign id_hit[k] = (paddr == OFS);
    end

    // Bus answer is prepared in the setup cycle so the access cycle completes with no wait.
    always_comb begin
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup_ph) begin
            pready_d = 1'b1;
            prdata_d = '0;
            if (lamp_hit) begin
                // The lamp word reads back the latch so software can see what it last wrote.
                prdata_d[BID_BIT_POS] = lamp_q;
            end else if (|id_hit) begin
                // Only the addressed position is returned, the others read as zero.
                prdata_d[BID_BIT_POS] = |(id_hit & id_now);
            end else begin
                // Unmapped words answer with an error and zero data.
                pslverr_d = 1'b1;
            end
        end else if (psel && penable && !pready_q) begin
            // A master that skipped the setup cycle still gets an answer next edge.
            pready_d  = 1'b1;
            pslverr_d = 1'b1;
        end
    end

    // Bus answer registers.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Lamp latch next value; the clear strobe wins over any write in the same cycle.
    always_comb begin
        lamp_d = lamp_q;
        if (io_latch_clear_strobe) begin
            lamp_d = BID_LAMP_LIT;
        end else if (access_done && pwrite && lamp_hit) begin
            // Bit zero of the write data is latched as is.
            lamp_d = pwdata[BID_BIT_POS];
        end
        // Writes to switch words fall through here and leave the latch alone.
    end

    // Reset acts as the power-up clear, so the lamp comes up lit.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lamp_q <= BID_LAMP_LIT;
        end else begin
            lamp_q <= lamp_d;
        end
    end

    // Every output leaves straight from a register.
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign status_lamp_n = lamp_q;

    // Writing zero to the lamp word lights the lamp one edge later.
    lamp_on_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && paddr == BID_LAMP_OFS && !pwdata[0])
        |=> (status_lamp_n == 1'b0)
    ) else $error("lamp not lit after zero write");

    // Writing one darkens the lamp unless a clear arrives at the same edge.
    lamp_off_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && paddr == BID_LAMP_OFS && pwdata[0]
         && !io_latch_clear_strobe)
        |=> (status_lamp_n == 1'b1)
    ) else $error("lamp not dark after one write");

    // The clear strobe lights the lamp and keeps it lit while it stays high.
    clear_forces_lit_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        io_latch_clear_strobe |=> !status_lamp_n
    ) else $error("clear strobe did not light lamp");

    // An open switch read completes with one in bit zero.
    id_open_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && (id_hit & id_now) != '0)
        |=> (pready && prdata == 32'h0000_0001)
    ) else $error("open switch did not read one");

    // A closed switch read completes with zero.
    id_closed_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && id_hit != '0 && (id_hit & id_now) == '0)
        |=> (pready && prdata == 32'h0000_0000 && !pslverr)
    ) else $error("closed switch did not read zero");

    // The third switch word returns exactly the third switch level.
    id_distinct_addr_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && paddr == 12'h00c)
        |=> (prdata[0] == $past(id_now[2]) && !pslverr)
    ) else $error("switch word returned wrong position");

    // A write to a switch word leaves the lamp unchanged.
    id_write_ignored_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && id_hit != '0 && !io_latch_clear_strobe)
        |=> $stable(status_lamp_n)
    ) else $error("switch word write changed lamp");

endmodule : bid_top

// >>> verif/bid_apb_host.sv
`timescale 1ns/10ps
// Host processor model: an APB master that runs one whole transfer per call.
module bid_apb_host
    import bid_pkg::*;
(
    // Clock.
    input  wire logic                  sys_clk,
    // APB master side.
    output logic                       psel,
    output logic                       penable,
    output logic                       pwrite,
    output logic      [BID_ADDR_W-1:0] paddr,
    output logic      [BID_DATA_W-1:0] pwdata,
    input  wire logic [BID_DATA_W-1:0] prdata,
    input  wire logic                  pready,
    input  wire logic                  pslverr
);
    // The bus is idle at time zero.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // One transfer; it starts at the next edge, so two calls never drive a line twice in one step.
    // Released address and data are inverted, so a stale value cannot pass for a live one.
    task automatic xfer(input logic w, input logic [BID_ADDR_W-1:0] a, input logic [BID_DATA_W-1:0] d,
                        output logic [BID_DATA_W-1:0] rd, output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // The wait has no bound here; the bench's cycle ceiling ends a hang.
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // bid_apb_host

// >>> verif/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the identification switches and the status lamp.
module testbench
    import bid_pkg::*;
;
    logic                  sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;  // Clock, reset, APB.
    logic [BID_ADDR_W-1:0] paddr;                                                // APB address.
    logic [BID_DATA_W-1:0] pwdata, prdata, rd;                                   // APB data.
    logic [BID_ID_W-1:0]   id_switch, sw;                                        // Switch levels.
    logic                  io_latch_clear_strobe, status_lamp_n, err;            // Strobe and lamp.
    int                    errors, n_compared, cycles;                           // Report counters.

    bid_apb_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                       .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bid_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                 .id_switch(id_switch), .io_latch_clear_strobe(io_latch_clear_strobe),
                 .status_lamp_n(status_lamp_n));

    // Free-running clock of 40 ns.
    always #20 sys_clk = ~sys_clk;

    // Cycle ceiling well above the few hundred cycles the run needs.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    // Expected read word for a single bit.
    function automatic logic [31:0] exp_bit(input logic b);
        return {31'h0, b};
    endfunction

    // Compare and count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One transfer with its expected read data and error flag.
    task automatic io(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic xe);
        host.xfer(w, a, d, rd, err);
        if (!w) chk(rd, x, "read data");
        chk(exp_bit(err), exp_bit(xe), "error flag");
    endtask

    // Lamp level, looked at once the edge's updates have landed.
    task automatic lamp(input logic x);
        #1;
        chk(exp_bit(status_lamp_n), exp_bit(x), "lamp drive");
    endtask

    // Report and stop.
    task end_of_test;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Main sequence.
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        id_switch = 5'h1f;
        io_latch_clear_strobe = 1'b0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        void'($urandom(98658));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        lamp(BID_LAMP_LIT);
        // All closed, all open, then random patterns.
        for (int i = 0; i < 12; i++) begin
            sw = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
            // Change the switches on an edge, then give the sampler one edge to take them.
            @(posedge sys_clk);
            id_switch <= sw;
            @(posedge sys_clk);
            for (int k = 0; k < 5; k++) io(1'b0, BID_ID_OFS + 12'(4 * k), '0, exp_bit(sw[k]), 1'b0);
        end
        // Lamp writes with random upper data bits; ends dark.
        for (int j = 0; j < 4; j++) begin
            io(1'b1, BID_LAMP_OFS, {31'($urandom), j[0]}, '0, 1'b0);
            lamp(j[0]);
        end
        // Writes of zero to switch words and to an unmapped word, and a read of an unmapped place, leave the lamp dark.
        for (int k = 0; k < 5; k++) io(1'b1, BID_ID_OFS + 12'(4 * k), '0, '0, 1'b0);
        io(1'b1, 12'h018, '0, '0, 1'b1);
        io(1'b0, 12'h002, '0, '0, 1'b1);
        lamp(BID_LAMP_OFF);
        io(1'b0, BID_LAMP_OFS, '0, exp_bit(BID_LAMP_OFF), 1'b0);
        // Clear strobe pulse lights the lamp.
        @(posedge sys_clk);
        io_latch_clear_strobe <= 1'b1;
        @(posedge sys_clk);
        io_latch_clear_strobe <= 1'b0;
        @(posedge sys_clk);
        lamp(BID_LAMP_LIT);
        // A second reset in mid-run lights it again.
        io(1'b1, BID_LAMP_OFS, 32'h1, '0, 1'b0);
        lamp(BID_LAMP_OFF);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        lamp(BID_LAMP_LIT);
        // First transfers after the release: the latch reads lit and the third switch reads its last applied level.
        io(1'b0, BID_LAMP_OFS, '0, exp_bit(BID_LAMP_LIT), 1'b0);
        io(1'b0, BID_ID_OFS + 12'(4 * 2), '0, exp_bit(sw[2]), 1'b0);
        end_of_test();
    end
endmodule // testbench
